/* File: rtl/fap_defs.svh */
// constants for the field access packet handler
`ifndef FAP_DEFS_SVH
`define FAP_DEFS_SVH
`define FAP_PREAMBLE_BYTE  8'h55
`define FAP_TYPE_READ      16'h5246
`define FAP_TYPE_GET       16'h4746
`define FAP_TYPE_ERROR     16'h1515
`define FAP_CRC_INIT       16'h1D0F
`define FAP_CRC_POLY       16'h1021
`define FAP_MAX_FIELDS     8'h10
`define FAP_REQ_BYTES      4'h2
`define FAP_RSP_BYTES      4'h4
`endif

/* File: rtl/fap_pkg.sv */
// types for the field access packet handler
package fap_pkg;
   typedef enum logic [1:0] {
      FAP_SRC_NONE,
      FAP_SRC_STORED,
      FAP_SRC_LIVE
   } fap_src_t;

   // field lookup request towards the field stores
   typedef struct packed {
      logic        valid;
      fap_src_t    src;
      logic [15:0] id;
   } fap_fetch_req_t;

   // field lookup answer from the field stores
   typedef struct packed {
      logic        valid;
      logic        ok;
      logic [15:0] value;
   } fap_fetch_rsp_t;

   // one serial byte with handshake
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } fap_byte_t;
endpackage : fap_pkg

/* File: rtl/fap_crc16.sv */
// byte-wise ccitt crc step
`timescale 1ns/1ps
`include "fap_defs.svh"
module fap_crc16 (
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data_in,
   output logic      [15:0] crc_out
);
   always_comb begin
      logic [15:0] c;
      c = crc_in ^ {data_in, 8'h00};
      for (int i = 0; i < 8; i++) begin
         if (c[15]) begin
            c = {c[14:0], 1'b0} ^ `FAP_CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule : fap_crc16

/* File: rtl/fap_handler.sv */
// field access packet handler: parses requests, builds responses
//
// Operation
// - stored read answers preamble, type, length, crc
// - stored payload: count, then id value pairs
// - live get reads working memory, all kinds
// - live values may span algorithm iterations
// - response lists only retrieved fields
// - any failed field also sends error frame
// - live get answer: type, 1+4n, crc
// - live payload: count, alternating id value
// - stored read fetches power-up nonvolatile fields
`timescale 1ns/1ps
`include "fap_defs.svh"
module fap_handler (
   input  wire logic               clk_sys_in,
   input  wire logic               nrst_in,
   input  wire fap_pkg::fap_byte_t rx_in,
   output logic                    rx_ready_out,
   output fap_pkg::fap_byte_t      tx_out,
   input  wire logic               tx_ready_in,
   output fap_pkg::fap_fetch_req_t fetch_out,
   input  wire fap_pkg::fap_fetch_rsp_t fetch_in,
   output logic                    busy_out
);
   typedef enum logic [3:0] {
      FAP_S_PRE0, FAP_S_PRE1, FAP_S_TYPH, FAP_S_TYPL, FAP_S_LEN,
      FAP_S_PAY, FAP_S_CRCH, FAP_S_CRCL, FAP_S_FETCH, FAP_S_WAIT,
      FAP_S_TX
   } fap_state_t;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   fap_state_t        state_r, state_nxt;
   logic [15:0]       type_r, type_nxt;
   logic [7:0]        len_r, len_nxt;
   logic [7:0]        cnt_r, cnt_nxt;
   logic [15:0]       crc_r, crc_nxt;
   logic [15:0]       rcrc_r, rcrc_nxt;
   logic [7:0]        req_r [0:63];
   logic [7:0]        rsp_r [0:63];
   logic              wr_req, wr_rsp;
   logic [5:0]        wr_rsp_idx;
   logic [4:0]        fidx_r, fidx_nxt;
   logic [4:0]        nok_r, nok_nxt;
   logic              err_r, err_nxt;
   logic              phase_r, phase_nxt;
   logic [7:0]        tcnt_r, tcnt_nxt;
   logic [7:0]        tlen_r, tlen_nxt;
   fap_pkg::fap_byte_t tx_r, tx_nxt;
   fap_pkg::fap_fetch_req_t fr_r, fr_nxt;
   logic [15:0]       crc_step;
   logic [7:0]        crc_byte;
   logic [4:0]        nreq;
   logic [7:0]        tbyte;

   fap_crc16 u_crc (
      .crc_in  (crc_r),
      .data_in (crc_byte),
      .crc_out (crc_step)
   );

   assign nreq = req_r[0][4:0];
   assign rx_ready_out = (state_r <= FAP_S_CRCL);
   assign tx_out = tx_r;
   assign fetch_out = fr_r;
   assign busy_out = (state_r >= FAP_S_FETCH);

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      type_nxt = type_r;
      len_nxt = len_r;
      cnt_nxt = cnt_r;
      crc_nxt = crc_r;
      rcrc_nxt = rcrc_r;
      fidx_nxt = fidx_r;
      nok_nxt = nok_r;
      err_nxt = err_r;
      phase_nxt = phase_r;
      tcnt_nxt = tcnt_r;
      tlen_nxt = tlen_r;
      tx_nxt = tx_r;
      fr_nxt = fr_r;
      wr_req = 1'b0;
      wr_rsp = 1'b0;
      wr_rsp_idx = '0;
      crc_byte = rx_in.data;
      tbyte = 8'h00;
      case (state_r)
         FAP_S_PRE0: begin
            crc_nxt = `FAP_CRC_INIT;
            if (rx_in.valid && rx_in.data == `FAP_PREAMBLE_BYTE) begin
               state_nxt = FAP_S_PRE1;
            end
         end
         FAP_S_PRE1: begin
            if (rx_in.valid) begin
               // drop on broken preamble
               state_nxt = (rx_in.data == `FAP_PREAMBLE_BYTE) ?
                           FAP_S_TYPH : FAP_S_PRE0;
            end
         end
         FAP_S_TYPH: begin
            if (rx_in.valid) begin
               type_nxt[15:8] = rx_in.data;
               crc_nxt = crc_step;
               state_nxt = FAP_S_TYPL;
            end
         end
         FAP_S_TYPL: begin
            if (rx_in.valid) begin
               type_nxt[7:0] = rx_in.data;
               crc_nxt = crc_step;
               state_nxt = FAP_S_LEN;
            end
         end
         FAP_S_LEN: begin
            if (rx_in.valid) begin
               len_nxt = rx_in.data;
               cnt_nxt = 8'h00;
               crc_nxt = crc_step;
               // odd length 1+2n, bounded
               if (!rx_in.data[0] || rx_in.data >
                   8'(`FAP_MAX_FIELDS * `FAP_REQ_BYTES + 1) ||
                   (type_r != `FAP_TYPE_READ &&
                    type_r != `FAP_TYPE_GET)) begin
                  state_nxt = FAP_S_PRE0;
               end else begin
                  state_nxt = FAP_S_PAY;
               end
            end
         end
         FAP_S_PAY: begin
            if (rx_in.valid) begin
               wr_req = 1'b1;
               crc_nxt = crc_step;
               cnt_nxt = cnt_r + 8'h01;
               if (cnt_r + 8'h01 == len_r) begin
                  state_nxt = FAP_S_CRCH;
               end
            end
         end
         FAP_S_CRCH: begin
            if (rx_in.valid) begin
               rcrc_nxt[15:8] = rx_in.data;
               state_nxt = FAP_S_CRCL;
            end
         end
         FAP_S_CRCL: begin
            if (rx_in.valid) begin
               fidx_nxt = '0;
               nok_nxt = '0;
               err_nxt = 1'b0;
               // count must match length, crc must match
               if ({rcrc_r[15:8], rx_in.data} == crc_r &&
                   {req_r[0], 1'b1} == {1'b0, len_r}) begin
                  state_nxt = FAP_S_FETCH;
               end else begin
                  state_nxt = FAP_S_PRE0;
               end
            end
         end
         FAP_S_FETCH: begin
            if (fidx_r == nreq) begin
               phase_nxt = 1'b0;
               tcnt_nxt = 8'h00;
               tlen_nxt = 8'(nok_r * `FAP_RSP_BYTES + 1);
               state_nxt = FAP_S_TX;
               if (nok_r == '0) begin
                  phase_nxt = 1'b1;
                  tlen_nxt = 8'h00;
               end
            end else begin
               fr_nxt.valid = 1'b1;
               // stored read vs live get source
               fr_nxt.src = (type_r == `FAP_TYPE_READ) ?
                            fap_pkg::FAP_SRC_STORED :
                            fap_pkg::FAP_SRC_LIVE;
               fr_nxt.id = {req_r[{fidx_r, 1'b1}],
                            req_r[6'({fidx_r, 1'b1}) + 6'd1]};
               state_nxt = FAP_S_WAIT;
            end
         end
         FAP_S_WAIT: begin
            fr_nxt.valid = 1'b0;
            // each value fetched on its own, no snapshot
            if (fetch_in.valid) begin
               fidx_nxt = fidx_r + 5'd1;
               if (fetch_in.ok) begin
                  // keep only retrieved pairs
                  nok_nxt = nok_r + 5'd1;
                  wr_rsp = 1'b1;
               end else begin
                  err_nxt = 1'b1;
               end
               state_nxt = FAP_S_FETCH;
            end
         end
         FAP_S_TX: begin
            // frame: 55 55 type len payload crc
            case (tcnt_r)
               8'h00, 8'h01: tbyte = `FAP_PREAMBLE_BYTE;
               8'h02: tbyte = phase_r ? 8'(`FAP_TYPE_ERROR >> 8) :
                              type_r[15:8];
               8'h03: tbyte = phase_r ? 8'(`FAP_TYPE_ERROR) :
                              type_r[7:0];
               8'h04: tbyte = tlen_r;
               default: begin
                  if (tcnt_r == tlen_r + 8'h05) tbyte = crc_r[15:8];
                  else if (tcnt_r == tlen_r + 8'h06) tbyte = crc_r[7:0];
                  else if (tcnt_r == 8'h05) tbyte = {3'b000, nok_r};
                  else tbyte = rsp_r[6'(tcnt_r - 8'h06)];
               end
            endcase
            crc_byte = tbyte;
            if (!tx_r.valid || tx_ready_in) begin
               tx_nxt.valid = 1'b1;
               tx_nxt.data = tbyte;
               tcnt_nxt = tcnt_r + 8'h01;
               if (tcnt_r == 8'h01) crc_nxt = `FAP_CRC_INIT;
               else if (tcnt_r < tlen_r + 8'h05) crc_nxt = crc_step;
               if (tcnt_r == tlen_r + 8'h06 && !phase_r && err_r) begin
                  // error frame follows the normal one
                  tcnt_nxt = 8'h00;
                  phase_nxt = 1'b1;
                  tlen_nxt = 8'h00;
               end else if (tcnt_r == tlen_r + 8'h07) begin
                  // crc low byte taken: stay until then, so no new
                  // request is parsed while a byte still waits
                  tx_nxt.valid = 1'b0;
                  state_nxt = FAP_S_PRE0;
               end
            end
         end
         default: state_nxt = FAP_S_PRE0;
      endcase
      wr_rsp_idx = 6'({nok_r, 2'b00});
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= FAP_S_PRE0;
         type_r <= '0;
         len_r <= '0;
         cnt_r <= '0;
         crc_r <= '0;
         rcrc_r <= '0;
         fidx_r <= '0;
         nok_r <= '0;
         err_r <= 1'b0;
         phase_r <= 1'b0;
         tcnt_r <= '0;
         tlen_r <= '0;
         tx_r <= '0;
         fr_r <= '0;
      end else begin
         state_r <= state_nxt;
         type_r <= type_nxt;
         len_r <= len_nxt;
         cnt_r <= cnt_nxt;
         crc_r <= crc_nxt;
         rcrc_r <= rcrc_nxt;
         fidx_r <= fidx_nxt;
         nok_r <= nok_nxt;
         err_r <= err_nxt;
         phase_r <= phase_nxt;
         tcnt_r <= tcnt_nxt;
         tlen_r <= tlen_nxt;
         tx_r <= tx_nxt;
         fr_r <= fr_nxt;
      end
   end

   // payload stores, no reset needed
   always_ff @(posedge clk_sys_in) begin
      if (wr_req) begin
         req_r[cnt_r[5:0]] <= rx_in.data;
      end
      if (wr_rsp) begin
         rsp_r[wr_rsp_idx]         <= fr_r.id[15:8];
         rsp_r[wr_rsp_idx + 6'd1]  <= fr_r.id[7:0];
         rsp_r[wr_rsp_idx + 6'd2]  <= fetch_in.value[15:8];
         rsp_r[wr_rsp_idx + 6'd3]  <= fetch_in.value[7:0];
      end
   end
endmodule : fap_handler

/* File: testbench/fap_handler_properties.sv */
// port checker for the field access packet handler
`timescale 1ns/1ps
module fap_handler_properties (
   input wire logic                    clk_sys_in,
   input wire logic                    nrst_in,
   input wire fap_pkg::fap_byte_t      rx_in,
   input wire logic                    rx_ready_out,
   input wire fap_pkg::fap_byte_t      tx_out,
   input wire logic                    tx_ready_in,
   input wire fap_pkg::fap_fetch_req_t fetch_out,
   input wire fap_pkg::fap_fetch_rsp_t fetch_in,
   input wire logic                    busy_out
);
   // ---------------------------------------------
   // sequences and properties
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   sequence s_stall;
      tx_out.valid && !tx_ready_in;
   endsequence
   sequence s_held;
      tx_out.valid && $stable(tx_out.data);
   endsequence
   sequence s_next;
      ##[1:4] (fetch_out.valid || tx_out.valid);
   endsequence

   a_tx_held: assert property (s_stall |=> s_held)
      else $error("tx byte changed while stalled");
   a_fetch_pulse: assert property (fetch_out.valid |=> !fetch_out.valid)
      else $error("fetch valid longer than one cycle");
   a_fetch_src: assert property (fetch_out.valid |-> fetch_out.src inside
      {fap_pkg::FAP_SRC_STORED, fap_pkg::FAP_SRC_LIVE})
      else $error("fetch without a field store");
   a_tx_preamble: assert property ($rose(tx_out.valid) |->
      tx_out.data == 8'h55)
      else $error("frame does not open with preamble");
   a_quiet_parse: assert property (rx_ready_out |->
      !tx_out.valid && !fetch_out.valid)
      else $error("output activity while parsing");
   a_busy_link: assert property (tx_out.valid |-> busy_out)
      else $error("transmit while not busy");
   a_answer_next: assert property (fetch_in.valid |-> s_next)
      else $error("no fetch or frame after an answer");
   a_ready_back: assert property ($fell(busy_out) |->
      ##[0:2] rx_ready_out)
      else $error("parser not back after response");
endmodule : fap_handler_properties

bind fap_handler fap_handler_properties i_fap_handler_properties (
   .clk_sys_in, .nrst_in, .rx_in, .rx_ready_out, .tx_out, .tx_ready_in,
   .fetch_out, .fetch_in, .busy_out);

/* File: testbench/fap_store_model.sv */
// field store stand-in answering fetch requests
`timescale 1ns/1ps
module fap_store_model (
   input  wire logic                    clk_sys_in,
   input  wire logic                    slow_in,
   input  wire fap_pkg::fap_fetch_req_t req_in,
   output fap_pkg::fap_fetch_rsp_t      rsp_out
);
   logic [15:0] id;
   logic [15:0] v;
   logic        ok;

   initial rsp_out = '0;

   // ids with the top bit set cannot be retrieved
   always @(posedge clk_sys_in) begin
      if (req_in.valid === 1'b1) begin
         id = req_in.id;
         ok = !id[15] && req_in.src != fap_pkg::FAP_SRC_NONE;
         v  = req_in.src == fap_pkg::FAP_SRC_LIVE ? id + 16'h0101
                                                 : id ^ 16'h5A5A;
         repeat (slow_in ? 4 : 0) @(posedge clk_sys_in);
         #1 rsp_out = {1'b1, ok, v};
         @(posedge clk_sys_in);
         #1 rsp_out = {1'b0, 1'b0, ~v};
      end
   end
endmodule : fap_store_model

/* File: testbench/tb_fap_handler.sv */
// self-checking bench for the field access packet handler
`timescale 1ns/1ps
module tb_fap_handler;
   typedef logic [7:0] fap_bq_t[$];
   logic                    clk_sys_in;
   logic                    nrst_in;
   logic                    tx_ready_in = 1'b1;
   logic                    slow;
   logic                    stall;
   logic                    rx_ready_out;
   logic                    busy_out;
   fap_pkg::fap_byte_t      rx_in;
   fap_pkg::fap_byte_t      tx_out;
   fap_pkg::fap_fetch_req_t fetch_out;
   fap_pkg::fap_fetch_rsp_t fetch_in;
   int                      n_mismatch;
   int                      checks;
   fap_bq_t                 got;

   fap_handler i_fap_handler (.clk_sys_in, .nrst_in, .rx_in, .rx_ready_out,
      .tx_out, .tx_ready_in, .fetch_out, .fetch_in, .busy_out);
   fap_store_model i_fap_store_model (.clk_sys_in, .slow_in(slow),
      .req_in(fetch_out), .rsp_out(fetch_in));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // sink: collects accepted bytes, stalls every other cycle on demand
   always @(posedge clk_sys_in) begin
      if (tx_out.valid === 1'b1 && tx_ready_in === 1'b1)
         got.push_back(tx_out.data);
      #1 tx_ready_in <= stall ? ~tx_ready_in : 1'b1;
   end

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic fap_bq_t frame(logic [15:0] typ, fap_bq_t pl);
      fap_bq_t     b;
      logic [15:0] c;
      b = {typ[15:8], typ[7:0], 8'(pl.size()), pl};
      c = 16'h1D0F;
      foreach (b[i]) begin
         c = c ^ {b[i], 8'h00};
         repeat (8) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
      end
      return {8'h55, 8'h55, b, c[15:8], c[7:0]};
   endfunction : frame

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // mode 0 good, 1 bad crc, 2 bad count from the caller's payload (no answer expected), 3 bad preamble
   task automatic xfer(logic [15:0] typ, fap_bq_t pl, int mode);
      fap_bq_t     rq, ok, ex, none;
      logic [15:0] id, v;
      int          n;
      rq = frame(typ, pl);
      if (mode == 1) rq[rq.size()-1] ^= 8'h01;
      if (mode == 3) rq[1] ^= 8'h01;
      for (int i = 1; i + 1 < pl.size(); i += 2) begin
         id = {pl[i], pl[i+1]};
         v  = typ == 16'h4746 ? id + 16'h0101 : id ^ 16'h5A5A;
         if (!id[15]) ok = {ok, id[15:8], id[7:0], v[15:8], v[7:0]};
      end
      if (ok.size() > 0) ex = frame(typ, {8'(ok.size() / 4), ok});
      if (ok.size() / 4 < (pl.size() - 1) / 2)
         ex = {ex, frame(16'h1515, none)};
      if (mode != 0) ex = none;
      got.delete();
      foreach (rq[i]) begin
         rx_in = {1'b1, rq[i]};
         for (n = 0; n < 100 && rx_ready_out !== 1'b1; n++)
            @(posedge clk_sys_in) #1;
         @(posedge clk_sys_in) #1;
      end
      rx_in = {1'b0, ~rq[rq.size()-1]};
      for (n = 0; n < 800 && got.size() < ex.size(); n++)
         @(posedge clk_sys_in);
      repeat (40) @(posedge clk_sys_in);
      #1;
      chk(got.size(), ex.size());
      foreach (ex[i]) if (i < got.size()) chk(got[i], ex[i]);
      chk(rx_ready_out, 1'b1);
   endtask : xfer

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_get_two;
      stall = 1'b1;
      xfer(16'h4746, '{8'h02, 8'h00, 8'h0A, 8'h01, 8'h23}, 0);
      stall = 1'b0;
   endtask : t_get_two

   task automatic t_read_one;
      slow = 1'b1;
      xfer(16'h5246, '{8'h01, 8'h00, 8'h05}, 0);
      slow = 1'b0;
   endtask : t_read_one

   task automatic t_partial;
      xfer(16'h4746, '{8'h03, 8'h00, 8'h11, 8'h80, 8'h02, 8'h02, 8'h33},
           0);
      xfer(16'h5246, '{8'h01, 8'h80, 8'h01}, 0);
   endtask : t_partial

   task automatic t_bad;
      xfer(16'h4746, '{8'h01, 8'h00, 8'h0A}, 1);
      xfer(16'h4746, '{8'h02, 8'h00, 8'h0A}, 2);
      xfer(16'h5246, '{8'h01, 8'h00, 8'h0A}, 3);
   endtask : t_bad

   task automatic t_max_fields;
      fap_bq_t pl;
      pl = {8'h10};
      for (int i = 0; i < 16; i++) pl = {pl, 8'h00, 8'(i * 3)};
      xfer(16'h4746, pl, 0);
   endtask : t_max_fields

   task automatic finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   initial begin
      rx_in       = '0;
      stall       = 1'b0;
      slow        = 1'b0;
      n_mismatch  = 0;
      checks      = 0;
      nrst_in     = 1'b0;
      repeat (8) @(posedge clk_sys_in);
      #1;
      chk(busy_out, 1'b0);
      nrst_in = 1'b1;
      t_get_two;
      t_read_one;
      t_partial;
      t_bad;
      t_max_fields;
      finish_test;
   end

   initial begin
      #400_000;
      n_mismatch++;
      finish_test;
   end
endmodule : tb_fap_handler
